// >>> decode_if.sv
`default_nettype none

interface decode_if;
  import store_decode_pkg::*;
  logic [7:0]  op;
  lead_t       lead;
  store_kind_t kind;
  source_t     src;
  modport decoder (input op, input lead, output kind, output src);
  modport user    (output op, output lead, input kind, input src);
endinterface

`default_nettype wire

// >>> indexed_and_direct_store_decode.sv
// Contract
// - DD/FD 36: fetch displacement and byte, store at index+d, 5 cycles native.
// - Second byte 77,70..75 stores A,B,C,D,E,H,L at index+d, 4 cycles.
// - DD/FD 0F/1F/2F store pair at index+d, 5 cycles short, 6 wide.
// - ED 6D copies accumulator to memory base only in wide mode, else 2-cycle no-op.
// - Opcode 32 stores accumulator direct, 2 address bytes/4 or 3 bytes/5 cycles.
// - DD/FD 22 stores index register direct, 6 cycles short, 8 cycles wide.
// - Prefix 5B forces long data and long direct addresses in short mode, 40 short ones in wide mode.
// - Mixed prefixes on direct stores: short-long takes memory base top, long-short takes 00 top.
// - ED 43/53 store first/second pair direct; 22 stores third pair one cycle faster.
// - ED 73 stores long stack pointer when wide, short stack pointer otherwise.
// - ED 4F copies accumulator to refresh counter in 2 cycles.
`include "store_decode_consts.svh"
`default_nettype none

module indexed_and_direct_store_decode (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        op_valid_i,
  input  wire logic [7:0]  op_byte_i,
  input  wire logic        wide_address_mode_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [23:0] first_register_pair_i,
  input  wire logic [23:0] second_register_pair_i,
  input  wire logic [23:0] third_register_pair_i,
  input  wire logic [23:0] first_index_register_i,
  input  wire logic [23:0] second_index_register_i,
  input  wire logic [23:0] long_stack_pointer_i,
  input  wire logic [15:0] short_stack_pointer_i,
  input  wire logic [7:0]  memory_base_upper_byte_i,
  output logic             op_ready_o,
  output logic             mem_wr_o,
  output logic [23:0]      mem_addr_o,
  output logic [7:0]       mem_data_o,
  output logic             memory_base_upper_byte_we_o,
  output logic [7:0]       memory_base_upper_byte_o,
  output logic             refresh_we_o,
  output logic [7:0]       refresh_o,
  output logic             flag_write_o,
  output logic             retire_o,
  output logic [3:0]       cycles_o,
  output logic             unclaimed_o
);
  import store_decode_pkg::*;

  // ----------------------------------------
  // Decode and state
  // ----------------------------------------
  state_t      state, next_state;
  lead_t       lead;
  store_kind_t kind_q;
  source_t     src_q;
  logic        sfx_seen, data_long, addr_long, taken, is_sfx, is_lead, load;
  logic        last_addr, skip_count, sil, lis;
  logic [7:0]  disp, addr_lo, addr_mid, disp_now;
  logic [1:0]  addr_cnt, wleft, n_bytes;
  logic [3:0]  cnt, next_cnt;
  logic [23:0] wdata, waddr, idx_base, idx_sum, idx_ea, dir_ea, src_value;
  decode_if    dec_bus ();
  store_opcode_decoder u_dec (.dec (dec_bus));

  assign dec_bus.op   = op_byte_i;
  assign dec_bus.lead = (state == S_IDLE) ? LEAD_NONE : lead;
  assign taken   = op_valid_i && op_ready_o;
  assign is_sfx  = (op_byte_i == `SFX_SHORT_SHORT) || (op_byte_i == `SFX_LONG_SHORT) ||
                   (op_byte_i == `SFX_SHORT_LONG) || (op_byte_i == `SFX_LONG_LONG);
  assign is_lead = (op_byte_i == `OPC_LEAD_IX) || (op_byte_i == `OPC_LEAD_IY) ||
                   (op_byte_i == `OPC_LEAD_EXT);
  assign load    = (state != S_WRITE) && (next_state == S_WRITE);
  assign last_addr = (addr_cnt == (addr_long ? `ADDR_BYTES_LONG : `ADDR_BYTES_SHORT) - 2'd1);
  assign sil     = sfx_seen && !data_long && addr_long;
  assign lis     = sfx_seen && data_long && !addr_long;

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (taken) begin
          if (!sfx_seen && is_sfx) begin
            next_state = S_IDLE;
          end else if (is_lead) begin
            next_state = S_OP2;
          end else if (dec_bus.kind == K_NONE) begin
            next_state = S_IDLE;
          end else begin
            next_state = S_ADDR;
          end
        end
      end
      S_OP2: begin
        if (taken) begin
          case (dec_bus.kind)
            K_IDX_IMM, K_IDX_REG, K_IDX_PAIR: next_state = S_DISP;
            K_DIR_IDX, K_DIR_PAIR, K_DIR_SP:  next_state = S_ADDR;
            default:                          next_state = S_IDLE;
          endcase
        end
      end
      S_DISP:  if (taken) next_state = (kind_q == K_IDX_IMM) ? S_IMM : S_WRITE;
      S_IMM:   if (taken) next_state = S_WRITE;
      S_ADDR:  if (taken && last_addr) next_state = S_WRITE;
      S_WRITE: if (wleft == 2'd0) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state      <= S_IDLE;
      op_ready_o <= 1'b0;
    end else begin
      state      <= next_state;
      op_ready_o <= (next_state != S_WRITE);
    end
  end

  // ----------------------------------------
  // Width prefixes and lead byte
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sfx_seen  <= 1'b0;
      data_long <= 1'b0;
      addr_long <= 1'b0;
      lead      <= LEAD_NONE;
    end else if (taken && state == S_IDLE) begin
      if (!sfx_seen && is_sfx) begin
        sfx_seen  <= 1'b1;
        data_long <= (op_byte_i == `SFX_LONG_SHORT) || (op_byte_i == `SFX_LONG_LONG);
        addr_long <= (op_byte_i == `SFX_SHORT_LONG) || (op_byte_i == `SFX_LONG_LONG);
      end else begin
        if (!sfx_seen) begin
          data_long <= wide_address_mode_i;
          addr_long <= wide_address_mode_i;
        end
        if (next_state == S_IDLE) begin
          sfx_seen <= 1'b0;
        end
        case (op_byte_i)
          `OPC_LEAD_IX:  lead <= LEAD_IX;
          `OPC_LEAD_IY:  lead <= LEAD_IY;
          `OPC_LEAD_EXT: lead <= LEAD_EXT;
          default:       lead <= LEAD_NONE;
        endcase
      end
    end else if (state != S_IDLE && next_state == S_IDLE) begin
      sfx_seen <= 1'b0;
    end
  end

  // ----------------------------------------
  // Operand capture
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      kind_q   <= K_NONE;
      src_q    <= SRC_A;
      disp     <= 8'h00;
      addr_lo  <= 8'h00;
      addr_mid <= 8'h00;
      addr_cnt <= 2'd0;
    end else if (taken) begin
      if ((state == S_IDLE || state == S_OP2) && dec_bus.kind != K_NONE) begin
        kind_q   <= dec_bus.kind;
        src_q    <= dec_bus.src;
        addr_cnt <= 2'd0;
      end
      if (state == S_DISP) begin
        disp <= op_byte_i;
      end
      if (state == S_ADDR) begin
        addr_cnt <= addr_cnt + 2'd1;
        if (addr_cnt == 2'd0) begin
          addr_lo <= op_byte_i;
        end else if (addr_cnt == 2'd1) begin
          addr_mid <= op_byte_i;
        end
      end
    end
  end

  // ----------------------------------------
  // Effective address and write data
  // ----------------------------------------
  assign disp_now = (state == S_DISP) ? op_byte_i : disp;
  assign idx_base = (lead == LEAD_IY) ? second_index_register_i : first_index_register_i;
  assign idx_sum  = idx_base + {{16{disp_now[7]}}, disp_now};
  // Short mode keeps the index sum inside the current 64K page
  assign idx_ea   = wide_address_mode_i ? idx_sum :
                    {memory_base_upper_byte_i, idx_sum[15:0]};
  always_comb begin
    if (addr_long) begin
      dir_ea = {sil ? memory_base_upper_byte_i : op_byte_i, addr_mid, addr_lo};
    end else begin
      dir_ea = {lis ? `ADDR_TOP_ZERO : memory_base_upper_byte_i, op_byte_i, addr_lo};
    end
  end
  always_comb begin
    case (src_q)
      SRC_A:     src_value = {16'h0000, acc_i};
      SRC_B:     src_value = {16'h0000, first_register_pair_i[15:8]};
      SRC_C:     src_value = {16'h0000, first_register_pair_i[7:0]};
      SRC_D:     src_value = {16'h0000, second_register_pair_i[15:8]};
      SRC_E:     src_value = {16'h0000, second_register_pair_i[7:0]};
      SRC_H:     src_value = {16'h0000, third_register_pair_i[15:8]};
      SRC_L:     src_value = {16'h0000, third_register_pair_i[7:0]};
      SRC_PAIR1: src_value = first_register_pair_i;
      SRC_PAIR2: src_value = second_register_pair_i;
      SRC_PAIR3: src_value = third_register_pair_i;
      SRC_IDX1:  src_value = first_index_register_i;
      SRC_IDX2:  src_value = second_index_register_i;
      SRC_SP:    src_value = data_long ? long_stack_pointer_i :
                             {8'h00, short_stack_pointer_i};
      SRC_IMM:   src_value = {16'h0000, op_byte_i};
      default:   src_value = 24'h000000;
    endcase
  end
  always_comb begin
    case (kind_q)
      K_IDX_IMM, K_IDX_REG, K_DIR_A: n_bytes = `DATA_BYTES_ONE;
      default: n_bytes = data_long ? `DATA_BYTES_LONG : `DATA_BYTES_SHORT;
    endcase
  end

  // ----------------------------------------
  // Memory write sequencing
  // ----------------------------------------
  // Bytes go out low first at rising addresses, one per cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mem_wr_o   <= 1'b0;
      mem_addr_o <= 24'h000000;
      mem_data_o <= 8'h00;
      wdata      <= 24'h000000;
      waddr      <= 24'h000000;
      wleft      <= 2'd0;
    end else if (load) begin
      mem_wr_o   <= 1'b1;
      mem_addr_o <= (state == S_ADDR) ? dir_ea : idx_ea;
      mem_data_o <= src_value[7:0];
      wdata      <= {8'h00, src_value[23:8]};
      waddr      <= ((state == S_ADDR) ? dir_ea : idx_ea) + 24'h000001;
      wleft      <= n_bytes - 2'd1;
    end else if (state == S_WRITE && wleft != 2'd0) begin
      mem_addr_o <= waddr;
      mem_data_o <= wdata[7:0];
      wdata      <= {8'h00, wdata[23:8]};
      waddr      <= waddr + 24'h000001;
      wleft      <= wleft - 2'd1;
    end else begin
      mem_wr_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register-only loads
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      memory_base_upper_byte_we_o   <= 1'b0;
      memory_base_upper_byte_o      <= 8'h00;
      refresh_we_o <= 1'b0;
      refresh_o    <= 8'h00;
      flag_write_o <= 1'b0;
    end else begin
      memory_base_upper_byte_we_o   <= taken && state == S_OP2 && dec_bus.kind == K_MEMORY_BASE_UPPER_BYTE &&
                      wide_address_mode_i;
      memory_base_upper_byte_o      <= acc_i;
      refresh_we_o <= taken && state == S_OP2 && dec_bus.kind == K_REFRESH;
      refresh_o    <= acc_i;
      flag_write_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Cycle accounting and retire
  // ----------------------------------------
  // One cycle per fetched byte and per written byte; a long-long suffix ahead of
  // opcode 32 overlaps with the opcode fetch and costs nothing
  // long prefix on 32
  assign skip_count = taken && state == S_IDLE && sfx_seen && data_long && addr_long &&
                      op_byte_i == `OPC_DIR_A;
  always_comb begin
    if (taken && state == S_IDLE && !sfx_seen) begin
      next_cnt = 4'd1;
    end else begin
      next_cnt = cnt + {3'b000, taken && !skip_count} + {3'b000, mem_wr_o};
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt <= 4'd0;
    end else begin
      cnt <= next_cnt;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      retire_o    <= 1'b0;
      cycles_o    <= 4'd0;
      unclaimed_o <= 1'b0;
    end else begin
      retire_o    <= 1'b0;
      unclaimed_o <= 1'b0;
      if ((load && n_bytes == 2'd1) || (state == S_WRITE && wleft == 2'd1)) begin
        retire_o <= 1'b1;
        cycles_o <= next_cnt + 4'd1;
      end else if (taken && state == S_OP2 &&
                   (dec_bus.kind == K_MEMORY_BASE_UPPER_BYTE || dec_bus.kind == K_REFRESH)) begin
        retire_o <= 1'b1;
        cycles_o <= `CYCLES_REG_ONLY;
      end
      if (taken && dec_bus.kind == K_NONE &&
          ((state == S_IDLE && !is_lead && !(is_sfx && !sfx_seen)) || state == S_OP2)) begin
        unclaimed_o <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> mem_partner.sv
`default_nettype none
module mem_partner (
  input wire logic        clk_i,
  input wire logic        mem_wr_i,
  input wire logic [23:0] addr_i,
  input wire logic [7:0]  data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus has no wait handshake, so memory can only take each byte at once
  logic [7:0]  cells [logic [23:0]];
  logic [31:0] wlog [$];
  always @(posedge clk_i) begin
    if (mem_wr_i === 1'b1) begin
      cells[addr_i] = data_i;
      wlog.push_back({addr_i, data_i});
    end
  end
endmodule
`default_nettype wire

// >>> store_decode_consts.svh
`ifndef STORE_DECODE_CONSTS_SVH
`define STORE_DECODE_CONSTS_SVH

// ----------------------------------------
// Lead bytes and width suffix bytes
// ----------------------------------------
`define OPC_LEAD_IX      8'hdd
`define OPC_LEAD_IY      8'hfd
`define OPC_LEAD_EXT     8'hed
`define SFX_SHORT_SHORT  8'h40
`define SFX_LONG_SHORT   8'h49
`define SFX_SHORT_LONG   8'h52
`define SFX_LONG_LONG    8'h5b

// ----------------------------------------
// Opcodes of the store group
// ----------------------------------------
`define OPC_IDX_IMM      8'h36
`define OPC_IDX_A        8'h77
`define OPC_IDX_B        8'h70
`define OPC_IDX_C        8'h71
`define OPC_IDX_D        8'h72
`define OPC_IDX_E        8'h73
`define OPC_IDX_H        8'h74
`define OPC_IDX_L        8'h75
`define OPC_IDX_PAIR1    8'h0f
`define OPC_IDX_PAIR2    8'h1f
`define OPC_IDX_PAIR3    8'h2f
`define OPC_EXT_MEMORY_BASE_UPPER_BYTE    8'h6d
`define OPC_EXT_REFRESH  8'h4f
`define OPC_DIR_A        8'h32
`define OPC_DIR_22       8'h22
`define OPC_EXT_PAIR1    8'h43
`define OPC_EXT_PAIR2    8'h53
`define OPC_EXT_SP       8'h73

// ----------------------------------------
// Widths, byte counts and timing
// ----------------------------------------
`define ADDR_TOP_ZERO    8'h00
`define ADDR_BYTES_LONG  2'd3
`define ADDR_BYTES_SHORT 2'd2
`define DATA_BYTES_LONG  2'd3
`define DATA_BYTES_SHORT 2'd2
`define DATA_BYTES_ONE   2'd1
`define CYCLES_REG_ONLY  4'd2

`endif

// >>> store_decode_pkg.sv
`default_nettype none

package store_decode_pkg;

  typedef enum logic [3:0] {
    K_NONE, K_IDX_IMM, K_IDX_REG, K_IDX_PAIR, K_MEMORY_BASE_UPPER_BYTE, K_REFRESH,
    K_DIR_A, K_DIR_IDX, K_DIR_PAIR, K_DIR_SP
  } store_kind_t;

  typedef enum logic [3:0] {
    SRC_A, SRC_B, SRC_C, SRC_D, SRC_E, SRC_H, SRC_L,
    SRC_PAIR1, SRC_PAIR2, SRC_PAIR3, SRC_IDX1, SRC_IDX2, SRC_SP, SRC_IMM
  } source_t;

  typedef enum logic [1:0] {LEAD_NONE, LEAD_IX, LEAD_IY, LEAD_EXT} lead_t;

  typedef enum {S_IDLE, S_OP2, S_DISP, S_IMM, S_ADDR, S_WRITE} state_t;

endpackage

`default_nettype wire

// >>> store_decode_sva.sv
`default_nettype none
module store_decode_sva (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        op_ready_o,
  input wire logic        mem_wr_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic        memory_base_upper_byte_we_o,
  input wire logic        refresh_we_o,
  input wire logic        flag_write_o,
  input wire logic        retire_o,
  input wire logic [3:0]  cycles_o,
  input wire logic        unclaimed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_no_flag; flag_write_o == 1'b0; endproperty
  a_no_flag: assert property (p_no_flag)
    else $error("flag write seen");
  property p_base_two; memory_base_upper_byte_we_o |-> retire_o && cycles_o == 4'h2; endproperty
  a_base_two: assert property (p_base_two)
    else $error("base copy not a two cycle retire");
  property p_refresh_two; refresh_we_o |-> retire_o && cycles_o == 4'h2; endproperty
  a_refresh_two: assert property (p_refresh_two)
    else $error("refresh copy not a two cycle retire");
  property p_busy; mem_wr_o |-> !op_ready_o; endproperty
  a_busy: assert property (p_busy)
    else $error("byte accepted during a write");
  // Wide values must land in consecutive bytes, so the address steps by one
  property p_step; mem_wr_o && !retire_o |=> mem_wr_o && mem_addr_o == $past(mem_addr_o) + 24'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("write burst broken or address not stepped");
  property p_run3; mem_wr_o [*3] |=> !mem_wr_o; endproperty
  a_run3: assert property (p_run3)
    else $error("more than three data bytes written");
  property p_ready_after; mem_wr_o && retire_o |=> op_ready_o; endproperty
  a_ready_after: assert property (p_ready_after)
    else $error("not ready after last write");
  property p_cyc_range; mem_wr_o && retire_o |-> cycles_o >= 4'h4 && cycles_o <= 4'h9;
  endproperty
  a_cyc_range: assert property (p_cyc_range)
    else $error("store cycle count out of range");
  property p_unc_quiet; unclaimed_o |-> !retire_o && !mem_wr_o && !memory_base_upper_byte_we_o; endproperty
  a_unc_quiet: assert property (p_unc_quiet)
    else $error("dropped bytes had an effect");
  property p_retire_pulse; retire_o |=> !retire_o; endproperty
  a_retire_pulse: assert property (p_retire_pulse)
    else $error("retire longer than one cycle");
endmodule
bind indexed_and_direct_store_decode store_decode_sva store_decode_sva_inst (
  .clk_i(clk_i), .nrst_i(nrst_i), .op_ready_o(op_ready_o), .mem_wr_o(mem_wr_o),
  .mem_addr_o(mem_addr_o), .memory_base_upper_byte_we_o(memory_base_upper_byte_we_o), .refresh_we_o(refresh_we_o),
  .flag_write_o(flag_write_o), .retire_o(retire_o), .cycles_o(cycles_o),
  .unclaimed_o(unclaimed_o));
`default_nettype wire

// >>> store_opcode_decoder.sv
`include "store_decode_consts.svh"
`default_nettype none

module store_opcode_decoder (
  decode_if.decoder dec
);
  import store_decode_pkg::*;

  always_comb begin
    dec.kind = K_NONE;
    dec.src  = SRC_A;
    case (dec.lead)
      LEAD_NONE: begin
        if (dec.op == `OPC_DIR_A) begin
          dec.kind = K_DIR_A;
          dec.src  = SRC_A;
        end else if (dec.op == `OPC_DIR_22) begin
          dec.kind = K_DIR_PAIR;
          dec.src  = SRC_PAIR3;
        end
      end
      LEAD_IX, LEAD_IY: begin
        case (dec.op)
          `OPC_IDX_IMM: begin
            dec.kind = K_IDX_IMM;
            dec.src  = SRC_IMM;
          end
          `OPC_IDX_A: begin dec.kind = K_IDX_REG; dec.src = SRC_A; end
          `OPC_IDX_B: begin dec.kind = K_IDX_REG; dec.src = SRC_B; end
          `OPC_IDX_C: begin dec.kind = K_IDX_REG; dec.src = SRC_C; end
          `OPC_IDX_D: begin dec.kind = K_IDX_REG; dec.src = SRC_D; end
          `OPC_IDX_E: begin dec.kind = K_IDX_REG; dec.src = SRC_E; end
          `OPC_IDX_H: begin dec.kind = K_IDX_REG; dec.src = SRC_H; end
          `OPC_IDX_L: begin dec.kind = K_IDX_REG; dec.src = SRC_L; end
          `OPC_IDX_PAIR1: begin dec.kind = K_IDX_PAIR; dec.src = SRC_PAIR1; end
          `OPC_IDX_PAIR2: begin dec.kind = K_IDX_PAIR; dec.src = SRC_PAIR2; end
          `OPC_IDX_PAIR3: begin dec.kind = K_IDX_PAIR; dec.src = SRC_PAIR3; end
          `OPC_DIR_22: begin
            dec.kind = K_DIR_IDX;
            dec.src  = (dec.lead == LEAD_IY) ? SRC_IDX2 : SRC_IDX1;
          end
          default: dec.kind = K_NONE;
        endcase
      end
      LEAD_EXT: begin
        case (dec.op)
          `OPC_EXT_MEMORY_BASE_UPPER_BYTE:   dec.kind = K_MEMORY_BASE_UPPER_BYTE;
          `OPC_EXT_REFRESH: dec.kind = K_REFRESH;
          `OPC_EXT_PAIR1: begin dec.kind = K_DIR_PAIR; dec.src = SRC_PAIR1; end
          `OPC_EXT_PAIR2: begin dec.kind = K_DIR_PAIR; dec.src = SRC_PAIR2; end
          `OPC_EXT_SP: begin dec.kind = K_DIR_SP; dec.src = SRC_SP; end
          default: dec.kind = K_NONE;
        endcase
      end
      default: dec.kind = K_NONE;
    endcase
  end

endmodule

`default_nettype wire

// >>> test_indexed_and_direct_store_decode.sv
`default_nettype none
module test_indexed_and_direct_store_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, valid, mode, rdy, wr, mbw, rfw, flw, ret, unc;
  logic [7:0]  op_b, acc, mb, wdat, mbv, rfv, mb_val, rf_val;
  logic [23:0] pr1, pr2, pr3, idx1, idx2, lsp, addr;
  logic [15:0] ssp, lf;
  logic [3:0]  cyc, last_cyc;
  logic [7:0]  q [$];
  logic [31:0] exp_w [$];
  int          n_fail, n_checks, ret_n, mb_n, rf_n, unc_n, e_cyc, e_mbw, e_rfw;
  logic [7:0]  idx_ops [11] = '{8'h36, 8'h77, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75,
                                8'h0f, 8'h1f, 8'h2f};
  logic [15:0] dir_ops [7] = '{16'h0032, 16'hdd22, 16'hfd22, 16'hed43, 16'hed53, 16'h0022,
                               16'hed73};
  logic [7:0]  sfx [5] = '{8'h00, 8'h40, 8'h49, 8'h52, 8'h5b};

  indexed_and_direct_store_decode indexed_and_direct_store_decode_inst (
    .clk_i(clk), .nrst_i(nrst), .op_valid_i(valid), .op_byte_i(op_b),
    .wide_address_mode_i(mode), .acc_i(acc), .first_register_pair_i(pr1),
    .second_register_pair_i(pr2), .third_register_pair_i(pr3), .first_index_register_i(idx1),
    .second_index_register_i(idx2), .long_stack_pointer_i(lsp), .short_stack_pointer_i(ssp),
    .memory_base_upper_byte_i(mb), .op_ready_o(rdy), .mem_wr_o(wr), .mem_addr_o(addr),
    .mem_data_o(wdat), .memory_base_upper_byte_we_o(mbw), .memory_base_upper_byte_o(mbv), .refresh_we_o(rfw), .refresh_o(rfv),
    .flag_write_o(flw), .retire_o(ret), .cycles_o(cyc), .unclaimed_o(unc));
  mem_partner mem_partner_inst (.clk_i(clk), .mem_wr_i(wr), .addr_i(addr), .data_i(wdat));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ret === 1'b1) begin
      ret_n++;
      last_cyc = cyc;
    end
    if (mbw === 1'b1) begin
      mb_n++;
      mb_val = mbv;
    end
    if (rfw === 1'b1) begin
      rf_n++;
      rf_val = rfv;
    end
    if (unc === 1'b1) unc_n++;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_n(string s, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, s, got, exp);
    end
  endtask

  task automatic chk_w(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t write got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction

  function automatic logic [23:0] r24();
    return {rnd(), rnd(), rnd()};
  endfunction

  task automatic regs();
    {acc, mb} = {rnd(), rnd()};
    {pr1, pr2, pr3} = {r24(), r24(), r24()};
    {idx1, idx2, lsp} = {r24(), r24(), r24()};
    ssp = 16'(r24());
  endtask

  // Reference: decode the byte list into expected writes and cycle count
  task automatic model();
    int          i, sf, dl, al, nb;
    logic [7:0]  lead, op;
    logic [23:0] a, v, x;
    {i, sf, lead, e_mbw, e_rfw} = {32'd0, 32'd0, 8'h00, 32'd0, 32'd0};
    exp_w = {};
    if (q[0] inside {8'h40, 8'h49, 8'h52, 8'h5b}) {sf, i} = {24'h0, q[0], 32'd1};
    dl = sf == 0 ? mode : (sf == 8'h49 || sf == 8'h5b);
    al = sf == 0 ? mode : (sf == 8'h52 || sf == 8'h5b);
    if (q[i] inside {8'hdd, 8'hfd, 8'hed}) {lead, i} = {q[i], i + 1};
    op = q[i];
    x = lead == 8'hdd ? idx1 : idx2;
    if (lead == 8'hed && op inside {8'h6d, 8'h4f}) begin
      {e_cyc, e_mbw, e_rfw} = {32'd2, 31'd0, op == 8'h6d && mode, 31'd0, op == 8'h4f};
      return;
    end
    if (lead inside {8'hdd, 8'hfd} && op != 8'h22) begin
      a = x + {{16{q[i+1][7]}}, q[i+1]};
      if (!mode) a = {mb, a[15:0]};
      nb = (op inside {8'h0f, 8'h1f, 8'h2f}) ? (dl ? 3 : 2) : 1;
      v = op == 8'h36 ? q[i+2] : op == 8'h77 ? acc : op == 8'h0f ? pr1 : op == 8'h1f ? pr2
        : op == 8'h2f ? pr3 : 24'({pr1[15:0], pr2[15:0], pr3[15:0]} >> (40 - 8 * (op - 8'h70)));
    end else begin
      a = al ? {(sf == 8'h52 ? mb : q[i+3]), q[i+2], q[i+1]}
             : {(sf == 8'h49 ? 8'h00 : mb), q[i+2], q[i+1]};
      nb = op == 8'h32 ? 1 : (dl ? 3 : 2);
      v = op == 8'h32 ? acc : op == 8'h43 ? pr1 : op == 8'h53 ? pr2
        : op == 8'h73 ? (dl ? lsp : {8'h00, ssp}) : lead == 8'h00 ? pr3 : x;
    end
    e_cyc = q.size() + nb - int'(sf == 8'h5b && op == 8'h32);
    for (int b = 0; b < nb; b++) exp_w.push_back({a + 24'(b), v[8*b +: 8]});
  endtask

  // Holds the byte until taken; a random idle cycle checks that stalls are not counted
  task automatic put(logic [7:0] b);
    int k;
    k = 0;
    if (rnd() < 8'h30) begin
      valid = 1'b0;
      @(posedge clk);
      #1;
    end
    {valid, op_b} = {1'b1, b};
    while (rdy !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 20) begin
      n_fail++;
      test_done();
    end
    @(posedge clk);
    #1;
  endtask

  task automatic run(bit bad);
    int r0, m0, f0, u0, k;
    if (!bad) model();
    {r0, m0, f0, u0, k} = {ret_n, mb_n, rf_n, unc_n, 32'd0};
    mem_partner_inst.wlog.delete();
    foreach (q[j]) put(q[j]);
    valid = 1'b0;
    while (ret_n == r0 && unc_n == u0 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 40) begin
      n_fail++;
      test_done();
    end
    if (bad) begin
      repeat (2) @(posedge clk);
      #1;
    end
    chk_n("retire", ret_n - r0, !bad);
    chk_n("unclaimed", unc_n - u0, bad);
    chk_n("writes", mem_partner_inst.wlog.size(), bad ? 0 : exp_w.size());
    chk_n("flags", flw, 1'b0);
    if (bad) return;
    chk_n("cycles", last_cyc, e_cyc);
    chk_n("base we", mb_n - m0, e_mbw);
    chk_n("refresh we", rf_n - f0, e_rfw);
    if (e_mbw) chk_n("base", mb_val, acc);
    if (e_rfw) chk_n("refresh", rf_val, acc);
    foreach (exp_w[j]) chk_w(mem_partner_inst.wlog[j], exp_w[j]);
  endtask

  initial begin
    {valid, op_b, mode, nrst, lf} = {1'b0, 8'h00, 1'b0, 1'b0, 16'd29288};
    regs();
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      foreach (idx_ops[o]) foreach (sfx[s]) for (int l = 0; l < 2; l++) begin
        if (s == 1 || s == 4) continue;
        regs();
        q = {};
        if (s != 0) q.push_back(sfx[s]);
        q.push_back(l ? 8'hfd : 8'hdd);
        q.push_back(idx_ops[o]);
        q.push_back(rnd());
        if (o == 0) q.push_back(rnd());
        run(1'b0);
      end
      foreach (dir_ops[o]) foreach (sfx[s]) begin
        regs();
        q = {};
        if (s != 0) q.push_back(sfx[s]);
        if (dir_ops[o][15:8] != 8'h00) q.push_back(dir_ops[o][15:8]);
        q.push_back(dir_ops[o][7:0]);
        repeat ((s == 3 || s == 4 || (s == 0 && m == 1)) ? 3 : 2) q.push_back(rnd());
        run(1'b0);
      end
      q = '{8'hed, 8'h6d};
      run(1'b0);
      q = '{8'hed, 8'h4f};
      run(1'b0);
    end
    q = '{8'hdd, 8'h21};
    run(1'b1);
    q = '{8'h40, 8'h40};
    run(1'b1);
    q = '{8'hed, 8'h01};
    run(1'b1);
    test_done();
  end
endmodule
`default_nettype wire
